// >>> pdm_pkg.sv
// Shared constants and types of the power-down mode controller
package pdm_pkg;

   // ======================================================
   // Register map (byte addresses on the register port)
   localparam logic [7:0] ADDR_STANDBY = 8'h00;
   localparam logic [7:0] ADDR_SYSTEM = 8'h04;
   localparam logic [7:0] ADDR_STOP_ONE = 8'h08;
   localparam logic [7:0] ADDR_STOP_TWO = 8'h0C;

   // ======================================================
   // Standby control layout
   localparam int SBY_SELECT_BIT = 7;
   localparam int SBY_FLOAT_BIT = 6;
   localparam int SBY_IRQ_BLOCK_BIT = 0;
   localparam logic [7:0] SBY_WRITE_MASK = 8'hC1;
   localparam logic [7:0] SBY_FIXED = 8'h1E;
   localparam logic [7:0] SBY_RESET = 8'h1F;
   localparam logic [7:0] SBY_GUARDED = 8'hC0;

   // ======================================================
   // System control layout
   localparam int SYS_TRACE_CLEAR_BIT = 1;
   localparam int SYS_RAM_ENABLE_BIT = 0;
   localparam logic [7:0] SYS_WRITE_MASK = 8'h03;
   localparam logic [7:0] SYS_FIXED = 8'hC0;
   localparam logic [7:0] SYS_RESET = 8'hC1;

   // ======================================================
   // Module-stop register one layout
   localparam int STOP1_RAM_BIT = 11;
   localparam int STOP1_ROM_BIT = 10;
   localparam int STOP1_XFER_HI_BIT = 9;
   localparam int STOP1_XFER_LO_BIT = 8;
   localparam int STOP1_SERIAL4_BIT = 4;
   localparam int STOP1_SERIAL3_BIT = 3;
   localparam int STOP1_SERIAL2_BIT = 2;
   localparam logic [15:0] STOP1_WRITE_MASK = 16'h0F1C;
   localparam logic [15:0] STOP1_FIXED = 16'hF023;
   localparam logic [15:0] STOP1_RESET = 16'hF03F;

   // ======================================================
   // Module-stop register two layout
   localparam int STOP2_MOTOR_BIT = 14;
   localparam int STOP2_MULTI_BIT = 13;
   localparam int STOP2_COMPARE_BIT = 12;
   localparam int STOP2_CONV1_BIT = 5;
   localparam int STOP2_CONV0_BIT = 4;
   localparam int STOP2_TRACE_BIT = 3;
   localparam int STOP2_DEBUG_IF_BIT = 2;
   localparam int STOP2_BREAK_BIT = 0;
   localparam logic [15:0] STOP2_WRITE_MASK = 16'h703D;
   localparam logic [15:0] STOP2_FIXED = 16'h8000;
   localparam logic [15:0] STOP2_RESET = 16'hF030;

   // ======================================================
   // Module indices of the halt and reset vectors
   localparam int MOD_COUNT = 16;
   localparam int MOD_RAM = 0;
   localparam int MOD_ROM = 1;
   localparam int MOD_XFER = 2;
   localparam int MOD_SERIAL2 = 3;
   localparam int MOD_SERIAL3 = 4;
   localparam int MOD_SERIAL4 = 5;
   localparam int MOD_MOTOR = 6;
   localparam int MOD_MULTI = 7;
   localparam int MOD_COMPARE = 8;
   localparam int MOD_CONV0 = 9;
   localparam int MOD_CONV1 = 10;
   localparam int MOD_TRACE = 11;
   localparam int MOD_DEBUG_IF = 12;
   localparam int MOD_BREAK = 13;
   localparam int MOD_WATCHDOG = 14;
   localparam int MOD_PORT = 15;

   // Modules that keep their contents when stopped
   localparam logic [15:0] MOD_KEEP_WHEN_STOPPED = 16'h1001;
   // Modules initialised in software standby
   localparam logic [15:0] MOD_CLEAR_IN_SW_STANDBY = 16'h0FFE;
   // Modules halted but retained in software standby
   localparam logic [15:0] MOD_HOLD_IN_SW_STANDBY = 16'h7001;
   // Modules that survive hardware standby
   localparam logic [15:0] MOD_KEEP_IN_HW_STANDBY = 16'h0001;

   // ======================================================
   // Types
   typedef enum logic [1:0] {
      PDM_NORMAL,
      PDM_SLEEP,
      PDM_SW_STANDBY,
      PDM_HW_STANDBY
   } pdm_mode_e;

   typedef struct packed {
      logic cpuHalt;
      logic cpuReset;
      logic clockGenStop;
      logic portHold;
      logic portFloat;
      logic nmiIgnore;
      logic ramAccessEnable;
      logic [15:0] moduleHalt;
      logic [15:0] moduleReset;
   } pdm_ctrl_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wrData;
      logic wr;
      logic rd;
   } pdm_bus_req_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wrData;
      logic wr;
      logic rd;
   } pdm_unused_t_s;

   localparam logic [15:0] DATA_ZERO = 16'h0000;

endpackage

// >>> pdm_power_down_control.sv
// Power-down mode controller: standby, system and module-stop control
`timescale 1ns/10ps
// What this block does
// - Sleep instruction enters sleep when standby select is 0, else software standby.
// - Standby select cannot become 1 while the watchdog runs.
// - Port float bit picks hold or high impedance for ports in software standby.
// - Port float bit cannot become 1 while the watchdog runs.
// - IRQ wake block bit gates IRQ wake from software standby; resets to 1.
// - Trace soft clear at 0 holds trace module in reset; resets to 0.
// - RAM access enable at 0 blocks RAM reads, fetches and writes; resets to 1.
// - A module-stop bit at 1 stops its module, except the unmapped debug port bit; transfer needs both its bits at 1; 0 resumes it.
// - Stop register one holds RAM, ROM, transfer and three serial stops.
// - Stop register two holds motor, multi and compare timer stops, reset 1.
// - Outside standby only stopped modules halt; most reset, RAM and debug port retain.
// - Retained modules halt but keep registers; CPU, RAM, debug port, break and watchdog in software standby.
// - Cleared modules initialise; ROM, transfer, serial, timers, converters, trace in standby.
// - Hardware standby stops clocks, resets all, floats ports, ignores NMI, keeps RAM.
// - Sleep halts the CPU only; clocks, interrupts and peripherals keep running.
// - After any reset the block starts in normal operation.
// - Reserved bits read fixed values and ignore written data.
// - Setting the trace stop bit reinitialises the trace module.
module pdm_power_down_control (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   input wire logic sleepExec,
   input wire logic sleepWake,
   input wire logic nmiWake,
   input wire logic [3:0] irqWake,
   input wire logic watchdogRun,
   input wire logic hardStandbyN,
   output pdm_pkg::pdm_ctrl_s ctrl,
   output pdm_pkg::pdm_mode_e mode
);

   // ======================================================
   // State record
   typedef struct packed {
      pdm_pkg::pdm_mode_e mode;
      logic [7:0] standbyControl;
      logic [7:0] systemControl;
      logic [15:0] moduleStopOne;
      logic [15:0] moduleStopTwo;
      logic [15:0] rdData;
      logic syncFirst;
      logic syncSecond;
      pdm_pkg::pdm_ctrl_s ctrl;
   } pdm_state_s;

   pdm_state_s state;
   pdm_state_s next_state;

   // ======================================================
   // Helpers

   // Merge written data with fixed reserved values
   function automatic logic [15:0] mergeWrite(
      input logic [15:0] data,
      input logic [15:0] writeMask,
      input logic [15:0] fixedBits
   );
      mergeWrite = (data & writeMask) | (fixedBits & ~writeMask);
   endfunction

   // Stop bits gathered into the module index order
   function automatic logic [15:0] gatherStops(
      input logic [15:0] stopOne,
      input logic [15:0] stopTwo
   );
      logic [15:0] v;
      v = pdm_pkg::DATA_ZERO;
      v[pdm_pkg::MOD_RAM] = stopOne[pdm_pkg::STOP1_RAM_BIT];
      v[pdm_pkg::MOD_ROM] = stopOne[pdm_pkg::STOP1_ROM_BIT];
      v[pdm_pkg::MOD_XFER] = stopOne[pdm_pkg::STOP1_XFER_HI_BIT]
         & stopOne[pdm_pkg::STOP1_XFER_LO_BIT];
      v[pdm_pkg::MOD_SERIAL2] = stopOne[pdm_pkg::STOP1_SERIAL2_BIT];
      v[pdm_pkg::MOD_SERIAL3] = stopOne[pdm_pkg::STOP1_SERIAL3_BIT];
      v[pdm_pkg::MOD_SERIAL4] = stopOne[pdm_pkg::STOP1_SERIAL4_BIT];
      v[pdm_pkg::MOD_MOTOR] = stopTwo[pdm_pkg::STOP2_MOTOR_BIT];
      v[pdm_pkg::MOD_MULTI] = stopTwo[pdm_pkg::STOP2_MULTI_BIT];
      v[pdm_pkg::MOD_COMPARE] = stopTwo[pdm_pkg::STOP2_COMPARE_BIT];
      v[pdm_pkg::MOD_CONV0] = stopTwo[pdm_pkg::STOP2_CONV0_BIT];
      v[pdm_pkg::MOD_CONV1] = stopTwo[pdm_pkg::STOP2_CONV1_BIT];
      v[pdm_pkg::MOD_TRACE] = stopTwo[pdm_pkg::STOP2_TRACE_BIT];
      v[pdm_pkg::MOD_BREAK] = stopTwo[pdm_pkg::STOP2_BREAK_BIT];
      gatherStops = v;
   endfunction

   // Control outputs for a mode and a register set
   function automatic pdm_pkg::pdm_ctrl_s buildCtrl(
      input pdm_pkg::pdm_mode_e m,
      input logic [7:0] sby,
      input logic [7:0] sys,
      input logic [15:0] stopOne,
      input logic [15:0] stopTwo
   );
      pdm_pkg::pdm_ctrl_s c;
      logic [15:0] stops;
      stops = gatherStops(stopOne, stopTwo);
      c.cpuHalt = 1'b0;
      c.cpuReset = 1'b0;
      c.clockGenStop = 1'b0;
      c.portHold = 1'b0;
      c.portFloat = 1'b0;
      c.nmiIgnore = 1'b0;
      c.ramAccessEnable = sys[pdm_pkg::SYS_RAM_ENABLE_BIT];
      // Module standby applies in every clocked mode
      c.moduleHalt = stops;
      c.moduleReset = stops & ~pdm_pkg::MOD_KEEP_WHEN_STOPPED;
      // Trace held in reset by soft clear or its stop bit
      if (!sys[pdm_pkg::SYS_TRACE_CLEAR_BIT]) begin
         c.moduleReset[pdm_pkg::MOD_TRACE] = 1'b1;
      end
      if (stopTwo[pdm_pkg::STOP2_TRACE_BIT]) begin
         c.moduleReset[pdm_pkg::MOD_TRACE] = 1'b1;
      end
      case (m)
         pdm_pkg::PDM_NORMAL: begin
            c.cpuHalt = 1'b0;
         end
         pdm_pkg::PDM_SLEEP: begin
            // CPU only; peripherals and clocks stay alive
            c.cpuHalt = 1'b1;
         end
         pdm_pkg::PDM_SW_STANDBY: begin
            c.cpuHalt = 1'b1;
            c.clockGenStop = 1'b1;
            c.moduleHalt = c.moduleHalt
               | pdm_pkg::MOD_HOLD_IN_SW_STANDBY
               | pdm_pkg::MOD_CLEAR_IN_SW_STANDBY;
            c.moduleReset = c.moduleReset
               | pdm_pkg::MOD_CLEAR_IN_SW_STANDBY;
            // Ports either hold or float
            if (sby[pdm_pkg::SBY_FLOAT_BIT]) begin
               c.portFloat = 1'b1;
            end else begin
               c.portHold = 1'b1;
            end
         end
         pdm_pkg::PDM_HW_STANDBY: begin
            c.cpuHalt = 1'b1;
            c.cpuReset = 1'b1;
            c.clockGenStop = 1'b1;
            c.portFloat = 1'b1;
            c.nmiIgnore = 1'b1;
            c.moduleHalt = 16'hFFFF;
            c.moduleReset = ~pdm_pkg::MOD_KEEP_IN_HW_STANDBY;
         end
         default: begin
            c.cpuHalt = 1'b0;
         end
      endcase
      buildCtrl = c;
   endfunction

   // ======================================================
   // Next state
   always_comb begin
      logic [7:0] sbyWrite;
      logic [7:0] sysWrite;
      logic pinStandby;
      logic irqWakeOk;
      sbyWrite = 8'h00;
      sysWrite = 8'h00;
      pinStandby = 1'b0;
      irqWakeOk = 1'b0;
      next_state = state;

      // Pin synchroniser, second stage only is read
      next_state.syncFirst = hardStandbyN;
      next_state.syncSecond = state.syncFirst;
      pinStandby = ~state.syncSecond;

      // Read data, one cycle after the strobe
      next_state.rdData = pdm_pkg::DATA_ZERO;
      if (regRd) begin
         case (regAddr)
            pdm_pkg::ADDR_STANDBY: begin
               next_state.rdData = {8'h00, state.standbyControl};
            end
            pdm_pkg::ADDR_SYSTEM: begin
               next_state.rdData = {8'h00, state.systemControl};
            end
            pdm_pkg::ADDR_STOP_ONE: begin
               next_state.rdData = state.moduleStopOne;
            end
            pdm_pkg::ADDR_STOP_TWO: begin
               next_state.rdData = state.moduleStopTwo;
            end
            default: begin
               next_state.rdData = pdm_pkg::DATA_ZERO;
            end
         endcase
      end

      // Register writes, effective at the next edge
      if (regWr) begin
         case (regAddr)
            pdm_pkg::ADDR_STANDBY: begin
               sbyWrite = 8'(mergeWrite({8'h00, regWrData[7:0]},
                  {8'h00, pdm_pkg::SBY_WRITE_MASK},
                  {8'h00, pdm_pkg::SBY_FIXED}));
               // Guarded bits may clear but not rise while watchdog runs
               if (watchdogRun) begin
                  sbyWrite = (sbyWrite & ~pdm_pkg::SBY_GUARDED)
                     | (sbyWrite & state.standbyControl
                        & pdm_pkg::SBY_GUARDED);
               end
               next_state.standbyControl = sbyWrite;
            end
            pdm_pkg::ADDR_SYSTEM: begin
               sysWrite = 8'(mergeWrite({8'h00, regWrData[7:0]},
                  {8'h00, pdm_pkg::SYS_WRITE_MASK},
                  {8'h00, pdm_pkg::SYS_FIXED}));
               next_state.systemControl = sysWrite;
            end
            pdm_pkg::ADDR_STOP_ONE: begin
               next_state.moduleStopOne = mergeWrite(regWrData,
                  pdm_pkg::STOP1_WRITE_MASK,
                  pdm_pkg::STOP1_FIXED);
            end
            pdm_pkg::ADDR_STOP_TWO: begin
               next_state.moduleStopTwo = mergeWrite(regWrData,
                  pdm_pkg::STOP2_WRITE_MASK,
                  pdm_pkg::STOP2_FIXED);
            end
            default: begin
               next_state.rdData = next_state.rdData;
            end
         endcase
      end

      // IRQ wake only when not blocked
      irqWakeOk = (|irqWake)
         & ~state.standbyControl[pdm_pkg::SBY_IRQ_BLOCK_BIT];

      // Mode sequencing
      case (state.mode)
         pdm_pkg::PDM_NORMAL: begin
            if (sleepExec) begin
               if (state.standbyControl[pdm_pkg::SBY_SELECT_BIT]) begin
                  next_state.mode = pdm_pkg::PDM_SW_STANDBY;
               end else begin
                  next_state.mode = pdm_pkg::PDM_SLEEP;
               end
            end
         end
         pdm_pkg::PDM_SLEEP: begin
            if (sleepWake || nmiWake) begin
               next_state.mode = pdm_pkg::PDM_NORMAL;
            end
         end
         pdm_pkg::PDM_SW_STANDBY: begin
            if (nmiWake || irqWakeOk) begin
               next_state.mode = pdm_pkg::PDM_NORMAL;
            end
         end
         pdm_pkg::PDM_HW_STANDBY: begin
            if (!pinStandby) begin
               next_state.mode = pdm_pkg::PDM_NORMAL;
            end
         end
         default: begin
            next_state.mode = pdm_pkg::PDM_NORMAL;
         end
      endcase

      // Hardware standby overrides all, registers back to reset
      if (pinStandby) begin
         next_state.mode = pdm_pkg::PDM_HW_STANDBY;
         next_state.standbyControl = pdm_pkg::SBY_RESET;
         next_state.systemControl = pdm_pkg::SYS_RESET;
         next_state.moduleStopOne = pdm_pkg::STOP1_RESET;
         next_state.moduleStopTwo = pdm_pkg::STOP2_RESET;
      end

      // Outputs follow the new register values
      next_state.ctrl = buildCtrl(next_state.mode,
         next_state.standbyControl, next_state.systemControl,
         next_state.moduleStopOne, next_state.moduleStopTwo);
   end

   // ======================================================
   // State register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state.mode <= pdm_pkg::PDM_NORMAL;
         state.standbyControl <= pdm_pkg::SBY_RESET;
         state.systemControl <= pdm_pkg::SYS_RESET;
         state.moduleStopOne <= pdm_pkg::STOP1_RESET;
         state.moduleStopTwo <= pdm_pkg::STOP2_RESET;
         state.rdData <= pdm_pkg::DATA_ZERO;
         state.syncFirst <= 1'b1;
         state.syncSecond <= 1'b1;
         state.ctrl <= buildCtrl(pdm_pkg::PDM_NORMAL,
            pdm_pkg::SBY_RESET, pdm_pkg::SYS_RESET,
            pdm_pkg::STOP1_RESET, pdm_pkg::STOP2_RESET);
      end else begin
         state <= next_state;
      end
   end

   // ======================================================
   // Outputs, all from flops
   assign regRdData = state.rdData;
   assign ctrl = state.ctrl;
   assign mode = state.mode;

endmodule

// >>> pdm_power_down_checker.sv
// Port-level assertions of the power-down mode controller
`timescale 1ns/10ps
module pdm_power_down_checker (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdData,
   input wire logic sleepExec,
   input wire logic sleepWake,
   input wire logic nmiWake,
   input wire logic [3:0] irqWake,
   input wire logic watchdogRun,
   input wire logic hardStandbyN,
   input wire pdm_pkg::pdm_ctrl_s ctrl,
   input wire pdm_pkg::pdm_mode_e mode
);
   // ======================================================
   // Helper: standby pin high long enough that it cannot win
   logic [2:0] pinHist;
   logic steady;
   // History of the standby pin
   always_ff @(posedge sys_clk) begin
      pinHist <= {pinHist[1:0], hardStandbyN};
   end
   assign steady = hardStandbyN & (&pinHist);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // ======================================================
   // Mode steps
   sequence s_sleep_req;
      sleepExec && mode == pdm_pkg::PDM_NORMAL && steady;
   endsequence
   sequence s_wake_req;
      steady && ((mode == pdm_pkg::PDM_SLEEP && (sleepWake || nmiWake))
         || (mode == pdm_pkg::PDM_SW_STANDBY && nmiWake));
   endsequence

   // ======================================================
   // Assertions
   a_read_data_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
      else $error("read data outside its one cycle");
   a_sleep_entry: assert property (s_sleep_req |=>
      (mode == pdm_pkg::PDM_SLEEP || mode == pdm_pkg::PDM_SW_STANDBY))
      else $error("sleep instruction did not leave normal mode");
   a_wake_to_normal: assert property (s_wake_req |=> mode == pdm_pkg::PDM_NORMAL)
      else $error("wake event did not return to normal");
   a_sleep_state: assert property (mode == pdm_pkg::PDM_SLEEP |-> ctrl.cpuHalt
      && !ctrl.clockGenStop && !ctrl.cpuReset && !ctrl.moduleHalt[pdm_pkg::MOD_WATCHDOG])
      else $error("sleep controls wrong");
   a_sw_standby_state: assert property (mode == pdm_pkg::PDM_SW_STANDBY |->
      ctrl.clockGenStop && ctrl.cpuHalt && !ctrl.cpuReset && ctrl.moduleReset[pdm_pkg::MOD_XFER]
      && !ctrl.moduleReset[pdm_pkg::MOD_WATCHDOG] && (ctrl.portHold != ctrl.portFloat))
      else $error("software standby controls wrong");
   a_hw_standby_state: assert property (mode == pdm_pkg::PDM_HW_STANDBY |->
      ctrl.clockGenStop && ctrl.portFloat && ctrl.nmiIgnore && ctrl.cpuReset
      && !ctrl.moduleReset[pdm_pkg::MOD_RAM] && ctrl.moduleReset[pdm_pkg::MOD_WATCHDOG])
      else $error("hardware standby controls wrong");
   a_hw_entry_time: assert property ($fell(hardStandbyN) |->
      ##[1:6] mode == pdm_pkg::PDM_HW_STANDBY)
      else $error("hardware standby not entered in time");
   a_hw_exit_time: assert property ($rose(hardStandbyN) |->
      ##[1:6] mode == pdm_pkg::PDM_NORMAL)
      else $error("hardware standby not left in time");
   a_normal_state: assert property (mode == pdm_pkg::PDM_NORMAL |-> !ctrl.cpuHalt
      && !ctrl.clockGenStop && !ctrl.portFloat && !ctrl.nmiIgnore)
      else $error("normal mode controls wrong");
   a_reset_start: assert property ($fell(reset) |-> mode == pdm_pkg::PDM_NORMAL
      && ctrl.ramAccessEnable && ctrl.moduleReset[pdm_pkg::MOD_TRACE])
      else $error("wrong state after reset");
endmodule

bind pdm_power_down_control pdm_power_down_checker u_pdm_power_down_checker (
   .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sleepExec(sleepExec),
   .sleepWake(sleepWake), .nmiWake(nmiWake), .irqWake(irqWake),
   .watchdogRun(watchdogRun), .hardStandbyN(hardStandbyN), .ctrl(ctrl), .mode(mode)
);

// >>> tb_pdm_power_down_control.sv
// Self-checking bench of the power-down mode controller
`timescale 1ns/10ps
module tb_pdm_power_down_control;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdData;
   logic sleepExec = 1'b0;
   logic sleepWake = 1'b0;
   logic nmiWake = 1'b0;
   logic [3:0] irqWake = 4'h0;
   logic watchdogRun = 1'b0;
   logic hardStandbyN = 1'b1;
   pdm_pkg::pdm_ctrl_s ctrl;
   pdm_pkg::pdm_mode_e mode;
   int n_fail = 0;
   int tests_run = 0;

   // ======================================================
   // Design and clock
   pdm_power_down_control u_pdm_power_down_control (
      .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sleepExec(sleepExec),
      .sleepWake(sleepWake), .nmiWake(nmiWake), .irqWake(irqWake),
      .watchdogRun(watchdogRun), .hardStandbyN(hardStandbyN), .ctrl(ctrl), .mode(mode)
   );
   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   // ======================================================
   // Tasks
   // Stop bit of module index i: six of register one, then four of register two
   function automatic logic [15:0] stopData(input int i);
      case (i)
         0: stopData = 16'h0800;
         1: stopData = 16'h0400;
         2: stopData = 16'h0300;
         3: stopData = 16'h0004;
         4: stopData = 16'h0008;
         5: stopData = 16'h0010;
         6: stopData = 16'h4000;
         7: stopData = 16'h2000;
         8: stopData = 16'h1000;
         9: stopData = 16'h0010;
         default: stopData = 16'h0000;
      endcase
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Write strobe stays up until the next task takes the bus
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regRd <= 1'b0;
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      regWr <= 1'b0;
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk);
      chk(regRdData, exp);
   endtask
   task automatic tick();
      @(posedge sys_clk);
      regWr <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic wdog(input logic v);
      @(posedge sys_clk);
      regWr <= 1'b0;
      watchdogRun <= v;
      @(negedge sys_clk);
   endtask
   task automatic pin(input logic v);
      @(posedge sys_clk);
      regWr <= 1'b0;
      hardStandbyN <= v;
      @(negedge sys_clk);
   endtask
   // One-cycle pulses of the CPU and wake events
   task automatic evt(input logic s, input logic w, input logic n, input logic [3:0] q);
      @(posedge sys_clk);
      regWr <= 1'b0;
      sleepExec <= s;
      sleepWake <= w;
      nmiWake <= n;
      irqWake <= q;
      @(posedge sys_clk);
      sleepExec <= 1'b0;
      sleepWake <= 1'b0;
      nmiWake <= 1'b0;
      irqWake <= 4'h0;
      @(negedge sys_clk);
   endtask
   task automatic wait_mode(input pdm_pkg::pdm_mode_e m);
      for (int i = 0; i < 10; i++) begin
         if (mode !== m) @(negedge sys_clk);
      end
      chk(16'(mode), 16'(m));
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ======================================================
   // Watchdog against a hang
   initial begin
      #20000;
      n_fail++;
      complete_run();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      chk(16'(mode), 16'(pdm_pkg::PDM_NORMAL));
      chk(16'(ctrl.ramAccessEnable), 16'h0001);
      chk(16'(ctrl.moduleReset[pdm_pkg::MOD_TRACE]), 16'h0001);
      rd(8'h00, 16'h001F);
      rd(8'h04, 16'h00C1);
      rd(8'h08, 16'hF03F);
      rd(8'h0C, 16'hF030);
      rd(8'h10, 16'h0000);
      wr(8'h04, 16'hFFFF);
      rd(8'h04, 16'h00C3);
      chk(16'(ctrl.moduleReset[pdm_pkg::MOD_TRACE]), 16'h0000);
      wr(8'h04, 16'h0000);
      tick();
      chk(16'(ctrl.ramAccessEnable), 16'h0000);
      chk(16'(ctrl.moduleReset[pdm_pkg::MOD_TRACE]), 16'h0001);
      wr(8'h04, 16'h0003);
      rd(8'h04, 16'h00C3);
      // Guarded standby bits against a running watchdog
      wdog(1'b1);
      wr(8'h00, 16'hFFC0);
      rd(8'h00, 16'h001E);
      wdog(1'b0);
      wr(8'h00, 16'h0080);
      rd(8'h00, 16'h009E);
      wdog(1'b1);
      wr(8'h00, 16'h0000);
      rd(8'h00, 16'h001E);
      wdog(1'b0);
      wr(8'h08, 16'h0000);
      wr(8'h0C, 16'h0000);
      rd(8'h08, 16'hF023);
      rd(8'h0C, 16'h8000);
      // Stop bits of module indices 0 to 9 on and off
      for (int i = 0; i < 10; i++) begin
         wr(i < 6 ? 8'h08 : 8'h0C, stopData(i));
         tick();
         chk(16'(ctrl.moduleHalt[i]), 16'h0001);
         chk(16'(ctrl.moduleReset[i]), 16'(i != pdm_pkg::MOD_RAM));
         wr(i < 6 ? 8'h08 : 8'h0C, 16'h0000);
         tick();
         chk(16'(ctrl.moduleHalt[i]), 16'h0000);
      end
      wr(8'h08, 16'h0100);
      tick();
      chk(16'(ctrl.moduleHalt[pdm_pkg::MOD_XFER]), 16'h0000);
      wr(8'h0C, 16'h0008);
      tick();
      chk(16'(ctrl.moduleReset[pdm_pkg::MOD_TRACE]), 16'h0001);
      // Sleep and software standby
      evt(1'b1, 1'b0, 1'b0, 4'h0);
      chk(16'(mode), 16'(pdm_pkg::PDM_SLEEP));
      chk(16'(ctrl.cpuHalt), 16'h0001);
      evt(1'b0, 1'b0, 1'b0, 4'hF);
      chk(16'(mode), 16'(pdm_pkg::PDM_SLEEP));
      evt(1'b0, 1'b1, 1'b0, 4'h0);
      chk(16'(mode), 16'(pdm_pkg::PDM_NORMAL));
      wr(8'h00, 16'h0080);
      evt(1'b1, 1'b0, 1'b0, 4'h0);
      chk(16'(mode), 16'(pdm_pkg::PDM_SW_STANDBY));
      chk(16'(ctrl.portHold), 16'h0001);
      evt(1'b0, 1'b0, 1'b0, 4'h4);
      chk(16'(mode), 16'(pdm_pkg::PDM_NORMAL));
      wr(8'h00, 16'h00C1);
      evt(1'b1, 1'b0, 1'b0, 4'h0);
      chk(16'(ctrl.portFloat), 16'h0001);
      evt(1'b0, 1'b0, 1'b0, 4'hF);
      chk(16'(mode), 16'(pdm_pkg::PDM_SW_STANDBY));
      evt(1'b0, 1'b0, 1'b1, 4'h0);
      chk(16'(mode), 16'(pdm_pkg::PDM_NORMAL));
      // Hardware standby returns the registers to their reset values
      wr(8'h08, 16'h0000);
      pin(1'b0);
      wait_mode(pdm_pkg::PDM_HW_STANDBY);
      chk(16'(ctrl.moduleReset[pdm_pkg::MOD_RAM]), 16'h0000);
      pin(1'b1);
      wait_mode(pdm_pkg::PDM_NORMAL);
      rd(8'h08, 16'hF03F);
      rd(8'h00, 16'h001F);
      complete_run();
   end
endmodule
